// *** hdl/lpr_pkg.sv ***
// Constants, state codes and the state record of the line interface primary register bank.
package lpr_pkg;

    // Channel count and host port widths.
    localparam int lpr_chan_n = 8;
    localparam int lpr_addr_w = 5;
    localparam int lpr_data_w = 8;

    // Register offsets of the primary bank, plus the bank pointer.
    localparam logic [4:0] lpr_off_rev = 5'h00;
    localparam logic [4:0] lpr_off_analog_loop = 5'h01;
    localparam logic [4:0] lpr_off_remote_loop = 5'h02;
    localparam logic [4:0] lpr_off_all_ones = 5'h03;
    localparam logic [4:0] lpr_off_sig_absent = 5'h04;
    localparam logic [4:0] lpr_off_drv_fault = 5'h05;
    localparam logic [4:0] lpr_off_sig_absent_mask = 5'h06;
    localparam logic [4:0] lpr_off_drv_fault_mask = 5'h07;
    localparam logic [4:0] lpr_off_sig_absent_evt = 5'h08;
    localparam logic [4:0] lpr_off_drv_fault_evt = 5'h09;
    localparam logic [4:0] lpr_off_soft_reset = 5'h0A;
    localparam logic [4:0] lpr_off_monitor = 5'h0B;
    localparam logic [4:0] lpr_off_digital_loop = 5'h0C;
    localparam logic [4:0] lpr_off_alarm_crit = 5'h0D;
    localparam logic [4:0] lpr_off_bank_ptr = 5'h1F;

    // Reset values and fixed read values.
    localparam logic [7:0] lpr_rst_cfg = 8'h00;
    localparam logic [7:0] lpr_rst_soft_reset = 8'hFF;
    localparam logic [7:0] lpr_bank_primary = 8'h00;
    localparam logic [7:0] lpr_rd_unmapped = 8'h00;

    // Field positions of the monitor configuration register.
    localparam int lpr_mc_lsb = 0;
    localparam int lpr_mc_msb = 3;
    localparam int lpr_mc_dir_bit = 3;
    localparam logic [2:0] lpr_mc_none = 3'h0;

    // Soft reset length: the time in microseconds and the derived cycle count.
    localparam int lpr_clk_period_ps = 40000;
    localparam int lpr_soft_rst_us = 1;
    localparam int lpr_soft_rst_cycles = (lpr_soft_rst_us * 1000000 + lpr_clk_period_ps - 1) / lpr_clk_period_ps;
    localparam int lpr_cnt_w = 5;
    localparam logic [4:0] lpr_soft_rst_last = 5'(lpr_soft_rst_cycles - 1);
    localparam logic [4:0] lpr_cnt_zero = 5'h00;
    localparam logic [4:0] lpr_cnt_one = 5'h01;

    // Operating state: normal running or inside a soft reset cycle.
    typedef enum logic [1:0] {
        lpr_st_run = 2'b01,
        lpr_st_reset = 2'b10
    } lpr_state_type;

    // Whole state of the register bank.
    typedef struct packed {
        lpr_state_type st;
        logic [4:0] cnt;
        logic [7:0] bank;
        logic [7:0] analog_loop;
        logic [7:0] remote_loop;
        logic [7:0] all_ones;
        logic [7:0] sig_absent_mask;
        logic [7:0] drv_fault_mask;
        logic [7:0] sig_absent_evt;
        logic [7:0] drv_fault_evt;
        logic [7:0] monitor;
        logic [7:0] digital_loop;
        logic [7:0] alarm_crit;
        logic [7:0] sig_absent_prev;
        logic [7:0] drv_fault_prev;
        logic [7:0] rdata;
        logic rvalid;
        logic irq;
        logic busy;
        logic [7:0] mon_rx;
        logic [7:0] mon_tx;
        logic [7:0] crit_etsi;
        logic crit_t1;
    } lpr_state_rec_type;

endpackage

// *** hdl/lpr_sync.sv ***
// Two-stage synchroniser for a bus of independent level signals.
`timescale 1ns/1ps
`default_nettype none
module lpr_sync
    import lpr_pkg::*;
#(
    parameter int width = lpr_chan_n
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);

    // Each bit crosses through its own pair of flip-flops; bits are not coherent with each other.
    genvar gi;
    generate
        for (gi = 0; gi < width; gi++) begin : g_bit
            logic meta_r;
            logic stable_r;
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    meta_r <= 1'b0;
                    stable_r <= 1'b0;
                end else begin
                    meta_r <= async_in[gi];
                    stable_r <= meta_r;
                end
            end
            assign sync_out[gi] = stable_r;
        end
    endgenerate

endmodule
`default_nettype wire

// *** hdl/lpr_regs.sv ***
// Primary register bank of the eight-channel line interface with its host port and event logic.
//
// Summary of operation
// - Offset 00H reads a fixed 8-bit revision code; writes have no effect.
// - Analog loop enable bit n puts channel n in analog loopback; resets to 0.
// - Remote loop enable bit n puts channel n in remote loopback; resets to 0.
// - All-ones transmit bit n sends all ones on channel n; resets to 0.
// - Signal absent status reads 1 per channel while loss of signal is seen.
// - Driver fault status reads 1 per channel while a driver fault is seen.
// - Signal absent mask bit 1 lets that channel raise loss-of-signal events.
// - Driver fault mask bit 1 lets that channel raise driver fault events.
// - Any change of loss-of-signal status sets its event bit when unmasked.
// - Reading the loss-of-signal status clears the signal absent event bits.
// - Any change of driver fault status sets its event bit when unmasked.
// - Reading the driver fault status clears the driver fault event bits.
// - Any write to the soft reset register restores all registers for 1 us.
// - Writing the soft reset register never changes its all-ones content.
// - Monitor select: 0 or 8 none, 1-7 receivers, 9-15 transmitters.
// - Digital loop enable bit n puts channel n in digital loopback; resets to 0.
// - In E1 mode alarm criteria bit picks G.775 (0) or ETSI 300 233 (1).
// - In T1 mode the T1.231 criterion applies regardless of the selection bit.
`timescale 1ns/1ps
`default_nettype none
module lpr_regs
    import lpr_pkg::*;
#(
    // Revision code; the value is arbitrary.
    parameter logic [7:0] rev_code_p = 8'h5A
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Host register port, synchronous to clk.
    input wire logic host_cs,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [4:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    // Line status from the analog front end, asynchronous.
    input wire logic [7:0] line_sig_absent,
    input wire logic [7:0] line_drv_fault,
    input wire logic line_e1_mode,
    // Per-channel controls to the datapath.
    output logic [7:0] analog_loop_enable,
    output logic [7:0] remote_loop_enable,
    output logic [7:0] digital_loop_enable,
    output logic [7:0] all_ones_transmit,
    // Monitor selection, one-hot by channel.
    output logic [7:0] monitor_rx_sel,
    output logic [7:0] monitor_tx_sel,
    // Loss-of-signal criterion selection.
    output logic [7:0] alarm_crit_etsi,
    output logic alarm_crit_t1,
    // Soft reset in progress and interrupt request.
    output logic soft_reset_busy,
    output logic irq_req
);

    lpr_state_rec_type s_r;
    lpr_state_rec_type s_nxt;
    logic [7:0] sig_absent_s;
    logic [7:0] drv_fault_s;
    logic [0:0] e1_mode_s;
    logic wr_req;
    logic rd_req;
    logic prim_sel;
    logic bank_sel;

    // Status and mode pins cross into the clock domain before any logic reads them.
    lpr_sync #(
        .width(lpr_chan_n)
    ) u_sync_sig_absent (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(line_sig_absent),
        .sync_out(sig_absent_s)
    );

    lpr_sync #(
        .width(lpr_chan_n)
    ) u_sync_drv_fault (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(line_drv_fault),
        .sync_out(drv_fault_s)
    );

    lpr_sync #(
        .width(1)
    ) u_sync_mode (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(line_e1_mode),
        .sync_out(e1_mode_s)
    );

    // Host strobes: a write wins over a read presented in the same cycle.
    assign wr_req = host_cs & host_wr;
    assign rd_req = host_cs & host_rd & ~host_wr;
    // The primary bank answers only while the bank pointer holds the primary value.
    assign prim_sel = (s_r.bank == lpr_bank_primary);
    assign bank_sel = (host_addr == lpr_off_bank_ptr);

    // Next-state logic for the whole bank.
    always_comb begin
        logic [7:0] rd_val;
        logic [7:0] sa_set;
        logic [7:0] df_set;
        logic [7:0] sa_clr;
        logic [7:0] df_clr;
        logic go_reset;
        logic [2:0] mc_chan;
        rd_val = lpr_rd_unmapped;
        sa_set = 8'h00;
        df_set = 8'h00;
        sa_clr = 8'h00;
        df_clr = 8'h00;
        go_reset = 1'b0;
        mc_chan = lpr_mc_none;
        s_nxt = s_r;
        s_nxt.rvalid = 1'b0;

        // Read multiplexer; bit n of each per-channel register value is channel n.
        if (bank_sel) begin
            rd_val = s_r.bank;
        end else if (prim_sel) begin
            case (host_addr)
                lpr_off_rev: rd_val = rev_code_p;
                lpr_off_analog_loop: rd_val = s_r.analog_loop;
                lpr_off_remote_loop: rd_val = s_r.remote_loop;
                lpr_off_all_ones: rd_val = s_r.all_ones;
                lpr_off_sig_absent: rd_val = sig_absent_s;
                lpr_off_drv_fault: rd_val = drv_fault_s;
                lpr_off_sig_absent_mask: rd_val = s_r.sig_absent_mask;
                lpr_off_drv_fault_mask: rd_val = s_r.drv_fault_mask;
                lpr_off_sig_absent_evt: rd_val = s_r.sig_absent_evt;
                lpr_off_drv_fault_evt: rd_val = s_r.drv_fault_evt;
                lpr_off_soft_reset: rd_val = lpr_rst_soft_reset;
                lpr_off_monitor: rd_val = s_r.monitor;
                lpr_off_digital_loop: rd_val = s_r.digital_loop;
                lpr_off_alarm_crit: rd_val = s_r.alarm_crit;
                default: rd_val = lpr_rd_unmapped;
            endcase
        end

        // A read answers one cycle later with a one-cycle valid pulse.
        if (rd_req) begin
            s_nxt.rdata = rd_val;
            s_nxt.rvalid = 1'b1;
        end

        // Reading a status register clears the matching event bits.
        if (rd_req && prim_sel && host_addr == lpr_off_sig_absent) begin
            sa_clr = 8'hFF;
        end
        if (rd_req && prim_sel && host_addr == lpr_off_drv_fault) begin
            df_clr = 8'hFF;
        end

        // Any edge of a status bit raises its event while the mask allows it.
        sa_set = (sig_absent_s ^ s_r.sig_absent_prev) & s_r.sig_absent_mask;
        df_set = (drv_fault_s ^ s_r.drv_fault_prev) & s_r.drv_fault_mask;
        s_nxt.sig_absent_prev = sig_absent_s;
        s_nxt.drv_fault_prev = drv_fault_s;

        // A new event in the cycle of the clearing read survives the clear.
        s_nxt.sig_absent_evt = (s_r.sig_absent_evt & ~sa_clr) | sa_set;
        s_nxt.drv_fault_evt = (s_r.drv_fault_evt & ~df_clr) | df_set;

        // Operating state and host writes.
        case (s_r.st)
            lpr_st_run: begin
                if (wr_req && bank_sel) begin
                    s_nxt.bank = host_wdata;
                end else if (wr_req && prim_sel) begin
                    case (host_addr)
                        lpr_off_analog_loop: s_nxt.analog_loop = host_wdata;
                        lpr_off_remote_loop: s_nxt.remote_loop = host_wdata;
                        lpr_off_all_ones: s_nxt.all_ones = host_wdata;
                        lpr_off_sig_absent_mask: s_nxt.sig_absent_mask = host_wdata;
                        lpr_off_drv_fault_mask: s_nxt.drv_fault_mask = host_wdata;
                        lpr_off_soft_reset: go_reset = 1'b1;
                        lpr_off_monitor: s_nxt.monitor = host_wdata;
                        lpr_off_digital_loop: s_nxt.digital_loop = host_wdata;
                        lpr_off_alarm_crit: s_nxt.alarm_crit = host_wdata;
                        default: s_nxt.bank = s_r.bank;
                    endcase
                end
                if (go_reset) begin
                    s_nxt.st = lpr_st_reset;
                    s_nxt.cnt = lpr_cnt_zero;
                end
            end
            lpr_st_reset: begin
                // Writes are ignored while the reset cycle runs; the cycle lasts the full count.
                if (s_r.cnt == lpr_soft_rst_last) begin
                    s_nxt.st = lpr_st_run;
                    s_nxt.cnt = lpr_cnt_zero;
                end else begin
                    s_nxt.cnt = s_r.cnt + lpr_cnt_one;
                end
            end
            default: begin
                s_nxt.st = lpr_st_run;
                s_nxt.cnt = lpr_cnt_zero;
            end
        endcase

        // Inside a reset cycle every register holds its default value.
        if (go_reset || s_r.st == lpr_st_reset) begin
            s_nxt.bank = lpr_bank_primary;
            s_nxt.analog_loop = lpr_rst_cfg;
            s_nxt.remote_loop = lpr_rst_cfg;
            s_nxt.all_ones = lpr_rst_cfg;
            s_nxt.sig_absent_mask = lpr_rst_cfg;
            s_nxt.drv_fault_mask = lpr_rst_cfg;
            s_nxt.sig_absent_evt = lpr_rst_cfg;
            s_nxt.drv_fault_evt = lpr_rst_cfg;
            s_nxt.monitor = lpr_rst_cfg;
            s_nxt.digital_loop = lpr_rst_cfg;
            s_nxt.alarm_crit = lpr_rst_cfg;
        end
        s_nxt.busy = (s_nxt.st == lpr_st_reset);

        // Interrupt request follows the event bits that will be held.
        s_nxt.irq = |{s_nxt.sig_absent_evt, s_nxt.drv_fault_evt};

        // Monitor decode: the low three bits pick a channel, the top bit picks transmit.
        mc_chan = s_nxt.monitor[lpr_mc_msb-1:lpr_mc_lsb];
        s_nxt.mon_rx = 8'h00;
        s_nxt.mon_tx = 8'h00;
        if (mc_chan != lpr_mc_none) begin
            if (s_nxt.monitor[lpr_mc_dir_bit]) begin
                s_nxt.mon_tx[mc_chan] = 1'b1;
            end else begin
                s_nxt.mon_rx[mc_chan] = 1'b1;
            end
        end

        // Criterion selection: the per-channel choice counts only in E1 mode.
        s_nxt.crit_etsi = s_nxt.alarm_crit & {lpr_chan_n{e1_mode_s[0]}};
        s_nxt.crit_t1 = ~e1_mode_s[0];
    end

    // State register; the asynchronous reset loads constants only.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r.st <= lpr_st_run;
            s_r.cnt <= lpr_cnt_zero;
            s_r.bank <= lpr_bank_primary;
            s_r.analog_loop <= lpr_rst_cfg;
            s_r.remote_loop <= lpr_rst_cfg;
            s_r.all_ones <= lpr_rst_cfg;
            s_r.sig_absent_mask <= lpr_rst_cfg;
            s_r.drv_fault_mask <= lpr_rst_cfg;
            s_r.sig_absent_evt <= lpr_rst_cfg;
            s_r.drv_fault_evt <= lpr_rst_cfg;
            s_r.monitor <= lpr_rst_cfg;
            s_r.digital_loop <= lpr_rst_cfg;
            s_r.alarm_crit <= lpr_rst_cfg;
            s_r.sig_absent_prev <= 8'h00;
            s_r.drv_fault_prev <= 8'h00;
            s_r.rdata <= 8'h00;
            s_r.rvalid <= 1'b0;
            s_r.irq <= 1'b0;
            s_r.busy <= 1'b0;
            s_r.mon_rx <= 8'h00;
            s_r.mon_tx <= 8'h00;
            s_r.crit_etsi <= 8'h00;
            s_r.crit_t1 <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs come straight from state flip-flops.
    assign host_rdata = s_r.rdata;
    assign host_rvalid = s_r.rvalid;
    assign analog_loop_enable = s_r.analog_loop;
    assign remote_loop_enable = s_r.remote_loop;
    assign digital_loop_enable = s_r.digital_loop;
    assign all_ones_transmit = s_r.all_ones;
    assign monitor_rx_sel = s_r.mon_rx;
    assign monitor_tx_sel = s_r.mon_tx;
    assign alarm_crit_etsi = s_r.crit_etsi;
    assign alarm_crit_t1 = s_r.crit_t1;
    assign soft_reset_busy = s_r.busy;
    assign irq_req = s_r.irq;

endmodule
`default_nettype wire

// *** tb/lpr_regs_asserts.sv ***
// Concurrent checks on the ports of the line interface primary register bank.
`timescale 1ns/1ps
`default_nettype none
module lpr_regs_chk
    import lpr_pkg::*;
#(
    parameter logic [7:0] rev_code_p = 8'h5A
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Host register port.
    input wire logic host_cs,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [4:0] host_addr,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    input wire logic host_rvalid,
    // Line status.
    input wire logic [7:0] line_sig_absent,
    input wire logic [7:0] line_drv_fault,
    input wire logic line_e1_mode,
    // Controls and status out of the bank.
    input wire logic [7:0] analog_loop_enable,
    input wire logic [7:0] remote_loop_enable,
    input wire logic [7:0] digital_loop_enable,
    input wire logic [7:0] all_ones_transmit,
    input wire logic [7:0] monitor_rx_sel,
    input wire logic [7:0] monitor_tx_sel,
    input wire logic [7:0] alarm_crit_etsi,
    input wire logic alarm_crit_t1,
    input wire logic soft_reset_busy,
    input wire logic irq_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic [7:0] bank_r;
    logic [7:0] wd_r;
    logic [4:0] cnt_r;
    logic wr_go;
    logic rd_go;
    logic prim;

    // Decoded host requests and whether the primary bank is visible.
    assign wr_go = host_cs && host_wr && !soft_reset_busy;
    assign rd_go = host_cs && host_rd && !host_wr;
    assign prim = bank_r == lpr_bank_primary;

    // Shadow of the bank pointer, the last write data and the busy length.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bank_r <= lpr_bank_primary;
            wd_r <= 8'h00;
            cnt_r <= lpr_cnt_zero;
        end else begin
            if (wr_go && host_addr == lpr_off_bank_ptr) begin
                bank_r <= host_wdata;
            end
            wd_r <= host_wdata;
            cnt_r <= soft_reset_busy ? cnt_r + lpr_cnt_one : lpr_cnt_zero;
        end
    end

    read_answer_a: assert property (rd_go |=> host_rvalid) else $error("read not answered");
    rdata_hold_a: assert property (!host_rvalid |-> $stable(host_rdata)) else $error("read data moved");
    rev_read_a: assert property (rd_go && prim && host_addr == lpr_off_rev |=> host_rdata == rev_code_p)
        else $error("revision code wrong");
    soft_read_a: assert property (rd_go && prim && host_addr == lpr_off_soft_reset |=> host_rdata == 8'hFF)
        else $error("soft reset register not all ones");
    hidden_read_a: assert property (rd_go && !prim && host_addr != lpr_off_bank_ptr |=> host_rdata == 8'h00)
        else $error("hidden bank readable");
    cfg_write_a: assert property (wr_go && prim && host_addr == lpr_off_analog_loop |=> analog_loop_enable == wd_r)
        else $error("analog loop write lost");
    soft_start_a: assert property (wr_go && prim && host_addr == lpr_off_soft_reset |=> soft_reset_busy &&
        analog_loop_enable == 8'h00 && all_ones_transmit == 8'h00 && !irq_req) else $error("soft reset not applied");
    soft_length_a: assert property ($fell(soft_reset_busy) |-> $past(cnt_r) == 5'd24)
        else $error("soft reset length wrong");
    busy_lock_a: assert property (soft_reset_busy && host_cs && host_wr |=> $stable(analog_loop_enable))
        else $error("write taken while busy");
    mon_rx_a: assert property (wr_go && prim && host_addr == lpr_off_monitor |=>
        monitor_rx_sel == ((wd_r[3] || wd_r[2:0] == 3'h0) ? 8'h00 : 8'h01 << wd_r[2:0])) else $error("rx monitor");
    mon_tx_a: assert property (wr_go && prim && host_addr == lpr_off_monitor |=>
        monitor_tx_sel == ((!wd_r[3] || wd_r[2:0] == 3'h0) ? 8'h00 : 8'h01 << wd_r[2:0])) else $error("tx monitor");
    crit_split_a: assert property (alarm_crit_t1 |-> alarm_crit_etsi == 8'h00) else $error("criterion clash");
    irq_hold_a: assert property (irq_req && !host_cs |=> irq_req) else $error("interrupt dropped");

    // Main scenarios reached.
    cover property (rd_go && host_addr == lpr_off_sig_absent_evt);
    cover property ($fell(soft_reset_busy));
    cover property ($rose(irq_req));
endmodule

bind lpr_regs lpr_regs_chk #(.rev_code_p(rev_code_p)) i_chk (.clk, .sys_rst, .host_cs, .host_wr, .host_rd,
    .host_addr, .host_wdata, .host_rdata, .host_rvalid, .line_sig_absent, .line_drv_fault, .line_e1_mode,
    .analog_loop_enable, .remote_loop_enable, .digital_loop_enable, .all_ones_transmit, .monitor_rx_sel,
    .monitor_tx_sel, .alarm_crit_etsi, .alarm_crit_t1, .soft_reset_busy, .irq_req);
`default_nettype wire

// *** tb/lpr_host_model.sv ***
// Host processor model that drives the register port of the bank.
`timescale 1ns/1ps
`default_nettype none
module lpr_host_model (
    // Clock.
    input wire logic clk,
    // Host register port.
    output logic host_cs,
    output logic host_wr,
    output logic host_rd,
    output logic [4:0] host_addr,
    output logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata
);
    // The port idles deselected with both strobes low.
    initial begin
        {host_cs, host_wr, host_rd, host_addr, host_wdata} = '0;
    end

    // One write, held across its taking edge; released lines show inverted values.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge clk);
        {host_cs, host_wr, host_rd, host_addr, host_wdata} = {3'b110, a, d};
        @(negedge clk);
        {host_cs, host_wr, host_addr, host_wdata} = {2'b00, ~a, ~d};
    endtask

    // One read; the data is captured while the answer stands.
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(negedge clk);
        {host_cs, host_wr, host_rd, host_addr} = {3'b101, a};
        @(negedge clk);
        {host_cs, host_rd, host_addr} = {2'b00, ~a};
        d = host_rdata;
    endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking testbench of the line interface primary register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lpr_pkg::*;
    localparam logic [7:0] tb_rev = 8'h3C; // Arbitrary revision code.
    localparam logic [4:0] rw_off [7] = '{lpr_off_analog_loop, lpr_off_remote_loop, lpr_off_all_ones,
        lpr_off_sig_absent_mask, lpr_off_drv_fault_mask, lpr_off_digital_loop, lpr_off_alarm_crit};
    logic clk, sys_rst, host_cs, host_wr, host_rd, host_rvalid, line_e1_mode, alarm_crit_t1;
    logic soft_reset_busy, irq_req;
    logic [4:0] host_addr;
    logic [7:0] host_wdata, host_rdata, line_sig_absent, line_drv_fault, analog_loop_enable;
    logic [7:0] remote_loop_enable, digital_loop_enable, all_ones_transmit, monitor_rx_sel, monitor_tx_sel;
    logic [7:0] alarm_crit_etsi, sel;
    logic [3:0] mc;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;
    int n;

    lpr_host_model i_host (.clk(clk), .host_cs(host_cs), .host_wr(host_wr), .host_rd(host_rd),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata));

    lpr_regs #(.rev_code_p(tb_rev)) i_dut (.clk(clk), .sys_rst(sys_rst), .host_cs(host_cs), .host_wr(host_wr),
        .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .line_sig_absent(line_sig_absent), .line_drv_fault(line_drv_fault),
        .line_e1_mode(line_e1_mode), .analog_loop_enable(analog_loop_enable),
        .remote_loop_enable(remote_loop_enable), .digital_loop_enable(digital_loop_enable),
        .all_ones_transmit(all_ones_transmit), .monitor_rx_sel(monitor_rx_sel), .monitor_tx_sel(monitor_tx_sel),
        .alarm_crit_etsi(alarm_crit_etsi), .alarm_crit_t1(alarm_crit_t1), .soft_reset_busy(soft_reset_busy),
        .irq_req(irq_req));

    // Compares one value and reports a mismatch.
    task automatic check(input string name, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask

    // Reads one register and checks the answer.
    task automatic chk_rd(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd(a, d);
        check("rvalid", 8'h01, {7'h00, host_rvalid});
        check("rdata", e, d);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("Checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Clock of 40 ns.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Cuts a hung run short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            results();
        end
    end

    // Main sequence of scenarios.
    initial begin
        sys_rst = 1'b1;
        line_sig_absent = 8'h00;
        line_drv_fault = 8'h00;
        line_e1_mode = 1'b1;
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        // Writes to read-only places, then every default value.
        i_host.wr(lpr_off_rev, 8'hFF);
        i_host.wr(lpr_off_sig_absent, 8'hFF);
        for (int i = 0; i < 14; i++) begin
            chk_rd(5'(i), (i == 0) ? tb_rev : ((i == 10) ? lpr_rst_soft_reset : lpr_rst_cfg));
        end
        // One channel bit per configuration register.
        for (int i = 0; i < 7; i++) begin
            i_host.wr(rw_off[i], 8'(8'h01 << i));
            chk_rd(rw_off[i], 8'(8'h01 << i));
        end
        check("analog", 8'h01, analog_loop_enable);
        check("remote", 8'h02, remote_loop_enable);
        check("all_ones", 8'h04, all_ones_transmit);
        check("digital", 8'h20, digital_loop_enable);
        check("etsi", 8'h40, alarm_crit_etsi);
        check("t1", 8'h00, {7'h00, alarm_crit_t1});
        line_e1_mode = 1'b0;
        repeat (4) @(negedge clk);
        check("etsi", 8'h00, alarm_crit_etsi);
        check("t1", 8'h01, {7'h00, alarm_crit_t1});
        // Every monitor selection code.
        for (int c = 0; c < 16; c++) begin
            mc = 4'(c);
            sel = (mc[2:0] == 3'h0) ? 8'h00 : 8'h01 << mc[2:0];
            i_host.wr(lpr_off_monitor, {4'h0, mc});
            check("mon_rx", mc[3] ? 8'h00 : sel, monitor_rx_sel);
            check("mon_tx", mc[3] ? sel : 8'h00, monitor_tx_sel);
        end
        // Masked and unmasked status changes, cleared by status reads.
        i_host.wr(lpr_off_sig_absent_mask, 8'h08);
        i_host.wr(lpr_off_drv_fault_mask, 8'h20);
        line_sig_absent = 8'h28;
        line_drv_fault = 8'h24;
        repeat (4) @(negedge clk);
        check("irq", 8'h01, {7'h00, irq_req});
        chk_rd(lpr_off_sig_absent_evt, 8'h08);
        chk_rd(lpr_off_drv_fault_evt, 8'h20);
        chk_rd(lpr_off_sig_absent, 8'h28);
        chk_rd(lpr_off_sig_absent_evt, 8'h00);
        check("irq", 8'h01, {7'h00, irq_req});
        chk_rd(lpr_off_drv_fault, 8'h24);
        chk_rd(lpr_off_drv_fault_evt, 8'h00);
        check("irq", 8'h00, {7'h00, irq_req});
        line_sig_absent = 8'h00;
        repeat (4) @(negedge clk);
        chk_rd(lpr_off_sig_absent_evt, 8'h08);
        chk_rd(lpr_off_sig_absent, 8'h00);
        // Soft reset with a write during the busy time.
        i_host.wr(lpr_off_soft_reset, 8'h00);
        check("busy", 8'h01, {7'h00, soft_reset_busy});
        check("analog", 8'h00, analog_loop_enable);
        check("irq", 8'h00, {7'h00, irq_req});
        i_host.wr(lpr_off_analog_loop, 8'hFF);
        n = 0;
        while (soft_reset_busy === 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check("busy_len", 8'(lpr_soft_rst_cycles - 2), 8'(n));
        check("analog", 8'h00, analog_loop_enable);
        chk_rd(lpr_off_sig_absent_mask, 8'h00);
        chk_rd(lpr_off_soft_reset, 8'hFF);
        // Expanded bank selected hides the primary bank.
        i_host.wr(lpr_off_bank_ptr, 8'hAA);
        i_host.wr(lpr_off_analog_loop, 8'hFF);
        chk_rd(lpr_off_analog_loop, 8'h00);
        i_host.wr(lpr_off_bank_ptr, lpr_bank_primary);
        chk_rd(lpr_off_analog_loop, 8'h00);
        chk_rd(5'h0E, lpr_rd_unmapped);
        results();
    end
endmodule
`default_nettype wire
